//--- verilog/epc_counter.sv
// Encoder pulse counter: quadrature count, latch capture, movement and frequency.
// Assumes encoder and latch pins asynchronous to hclk; AHB-Lite single-word slave.
//
// Summary of operation
// - Quadrature mode counts every edge of both phases, four counts per encoder cycle.
// - A latch input going inactive to active copies the count into a readable latch register.
// - The capture is pure hardware, taken at the edge without software action.
// - Cycle mode reports the count change at each controller cycle pulse, count kept running.
// - Timed mode reports the count change every 1 to 9999 ms, free of the controller cycle.
// - Frequency is measured on pulse input one whether or not counting is enabled.
`timescale 1ns/1ps
`default_nettype none
module epc_counter
  import epc_pkg::*;
#(
  parameter int MS_CYCLES = EPC_MS_CYCLES,
  parameter int GATE_CYCLES = EPC_GATE_CYCLES
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic latch_in,
  input wire logic cycle_tick,
  output logic delta_valid
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  logic a_s;
  logic b_s;
  logic l_s;
  assign a_s = sync2_reg[0];
  assign b_s = sync2_reg[1];
  assign l_s = sync2_reg[2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      sync1_reg <= {latch_in, enc_b, enc_a};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registers and bus
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [13:0] period_reg;
  logic [31:0] present_count_value_reg;
  logic [31:0] latch_reg;
  logic [31:0] delta_reg;
  logic [31:0] base_reg;
  logic [31:0] freq_reg;
  logic latched_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic clr_req;
  logic latch_ack;
  logic [31:0] rd_data;
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      EPC_CTRL_OFS: rd_mux = {30'h0, ctrl_reg};
      EPC_PERIOD_OFS: rd_mux = {18'h0, period_reg};
      EPC_COUNT_OFS: rd_mux = present_count_value_reg;
      EPC_LATCH_OFS: rd_mux = latch_reg;
      EPC_DELTA_OFS: rd_mux = delta_reg;
      EPC_FREQ_OFS: rd_mux = freq_reg;
      EPC_STATUS_OFS: rd_mux = {31'h0, latched_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux
  always_comb
  begin
    rd_data = rd_mux({haddr[7:2], 2'b00});
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok)
      begin
        wr_addr_reg <= {haddr[7:2], 2'b00};
        if (!hwrite)
        begin
          hrdata <= rd_data;
        end
      end
    end
  end

  assign clr_req = wr_pend_reg && (wr_addr_reg == EPC_CTRL_OFS) && hwdata[EPC_CTRL_CLR_BIT];
  assign latch_ack = wr_pend_reg && (wr_addr_reg == EPC_STATUS_OFS) && hwdata[0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= EPC_CTRL_RESET;
      period_reg <= EPC_PERIOD_RESET;
    end
    else if (clk_en && wr_pend_reg)
    begin
      if (wr_addr_reg == EPC_CTRL_OFS)
      begin
        ctrl_reg <= {hwdata[EPC_CTRL_TIMED_BIT], hwdata[EPC_CTRL_EN_BIT]};
      end
      if (wr_addr_reg == EPC_PERIOD_OFS)
      begin
        if (hwdata[13:0] < EPC_PERIOD_MS_MIN)
          period_reg <= EPC_PERIOD_MS_MIN;
        else if (hwdata[13:0] > EPC_PERIOD_MS_MAX)
          period_reg <= EPC_PERIOD_MS_MAX;
        else
          period_reg <= hwdata[13:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Quadrature decode
  // ----------------------------------------------------------------
  logic [1:0] ab_now;
  logic [1:0] ab_old;
  logic step_up;
  logic step_dn;
  assign ab_now = {a_s, b_s};
  assign ab_old = {prev_reg[0], prev_reg[1]};
  always_comb
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    unique case ({ab_old, ab_now})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step_up = 1'b1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step_dn = 1'b1;
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      present_count_value_reg <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (clr_req)
        present_count_value_reg <= 32'h0000_0000;
      else if (ctrl_reg[EPC_CTRL_EN_BIT] && step_up)
        present_count_value_reg <= present_count_value_reg + 32'h0000_0001;
      else if (ctrl_reg[EPC_CTRL_EN_BIT] && step_dn)
        present_count_value_reg <= present_count_value_reg - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Latch capture
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_reg <= 32'h0000_0000;
      latched_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (l_s && !prev_reg[2])
      begin
        latch_reg <= present_count_value_reg;
        latched_reg <= 1'b1;
      end
      else if (latch_ack)
        latched_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Movement monitoring
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_reg;
  logic [13:0] per_cnt_reg;
  logic ms_tick;
  logic period_end;
  logic sample;
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
  assign period_end = ms_tick && (per_cnt_reg >= period_reg - 14'd1);
  assign sample = ctrl_reg[EPC_CTRL_TIMED_BIT] ? period_end : cycle_tick;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ms_cnt_reg <= 32'h0000_0000;
      per_cnt_reg <= 14'd0;
    end
    else if (clk_en)
    begin
      ms_cnt_reg <= ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
      if (period_end)
        per_cnt_reg <= 14'd0;
      else if (ms_tick)
        per_cnt_reg <= per_cnt_reg + 14'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      delta_reg <= 32'h0000_0000;
      base_reg <= 32'h0000_0000;
      delta_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      delta_valid <= sample;
      if (sample)
      begin
        delta_reg <= present_count_value_reg - base_reg;
        base_reg <= present_count_value_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frequency on pulse input one
  // ----------------------------------------------------------------
  logic [31:0] gate_cnt_reg;
  logic [31:0] edge_cnt_reg;
  logic a_rise;
  assign a_rise = a_s && !prev_reg[0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gate_cnt_reg <= 32'h0000_0000;
      edge_cnt_reg <= 32'h0000_0000;
      freq_reg <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (gate_cnt_reg == 32'(GATE_CYCLES - 1))
      begin
        gate_cnt_reg <= 32'h0000_0000;
        freq_reg <= edge_cnt_reg + {31'h0, a_rise};
        edge_cnt_reg <= 32'h0000_0000;
      end
      else
      begin
        gate_cnt_reg <= gate_cnt_reg + 32'h0000_0001;
        edge_cnt_reg <= edge_cnt_reg + {31'h0, a_rise};
      end
    end
  end
endmodule : epc_counter
`default_nettype wire

//--- verilog/epc_pkg.sv
// Package for the encoder pulse counter: register map, field layout, timing counts.
// Assumes a 200 MHz hclk and a 32-bit AHB-Lite register bus.
package epc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] EPC_PERIOD_OFS = 8'h04;
  localparam logic [7:0] EPC_COUNT_OFS = 8'h08;
  localparam logic [7:0] EPC_LATCH_OFS = 8'h0C;
  localparam logic [7:0] EPC_DELTA_OFS = 8'h10;
  localparam logic [7:0] EPC_FREQ_OFS = 8'h14;
  localparam logic [7:0] EPC_STATUS_OFS = 8'h18;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int EPC_CTRL_EN_BIT = 0;
  localparam int EPC_CTRL_TIMED_BIT = 1;
  localparam int EPC_CTRL_CYCLE_BIT = 2;
  localparam int EPC_CTRL_CLR_BIT = 3;
  localparam logic [1:0] EPC_CTRL_RESET = 2'h0;
  localparam logic [13:0] EPC_PERIOD_MS_MIN = 14'd1;
  localparam logic [13:0] EPC_PERIOD_MS_MAX = 14'd9999;
  localparam logic [13:0] EPC_PERIOD_RESET = 14'd1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int EPC_CLK_HZ = 200_000_000;
  localparam int EPC_MS_NS = 1_000_000;
  localparam int EPC_CLK_NS = 5;
  localparam int EPC_MS_CYCLES = EPC_MS_NS / EPC_CLK_NS;
  localparam int EPC_GATE_MS = 1;
  localparam int EPC_GATE_CYCLES = EPC_GATE_MS * EPC_MS_CYCLES;
endpackage : epc_pkg

//--- sim/epc_counter_properties.sv
// Port checker for the encoder pulse counter.
// Assumes hready is tied to hreadyout and one hclk domain.
`timescale 1ns/1ps
`default_nettype none
module epc_counter_props
  import epc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cycle_tick,
  input wire logic delta_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Shadow of the timed mode bit
  // ----------------------------------------------------------------
  logic wr_phase_reg;
  logic [7:0] wr_ofs_reg;
  logic timed_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_phase_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      timed_reg <= EPC_CTRL_RESET[EPC_CTRL_TIMED_BIT];
    end
    else if (clk_en)
    begin
      wr_phase_reg <= hsel && hready && htrans[1] && hwrite;
      wr_ofs_reg <= {haddr[7:2], 2'b00};
      if (wr_phase_reg && (wr_ofs_reg == EPC_CTRL_OFS))
        timed_reg <= hwdata[EPC_CTRL_TIMED_BIT];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus wait or error");
  read_hold_a: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite && clk_en) |-> $stable(hrdata))
    else $error("read data moved without a read");
  tick_delta_a: assert property (cycle_tick && clk_en && !timed_reg |=> delta_valid)
    else $error("no delta after cycle tick");
  tick_only_a: assert property (clk_en && !timed_reg && !cycle_tick |=> !delta_valid)
    else $error("delta without cycle tick");
  delta_pulse_a: assert property (
    $past(timed_reg) && timed_reg && delta_valid |=> !delta_valid [*8])
    else $error("delta update too soon");
  freeze_hold_a: assert property (!clk_en |=> $stable(hrdata) && $stable(delta_valid))
    else $error("state moved while frozen");
endmodule : epc_counter_props
bind epc_counter epc_counter_props u_props (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .cycle_tick, .delta_valid);
`default_nettype wire

//--- sim/epc_enc_model.sv
// Rotary encoder and latch sensor model.
// Assumes its tasks are entered just after a rising hclk edge.
`timescale 1ns/1ps
`default_nettype none
module epc_enc_model
(
  input wire logic hclk,
  output logic enc_a,
  output logic enc_b,
  output logic latch_in
);
  logic [1:0] ph = 2'h0;
  // gray order 00 10 11 01
  assign enc_a = ph[0] ^ ph[1];
  assign enc_b = ph[1];
  initial latch_in = 1'b0;
  task automatic move(input int n, input bit up, input int gap);
    for (int i = 0; i < n; i++)
    begin
      ph <= up ? ph + 2'h1 : ph - 2'h1;
      repeat (gap) @(posedge hclk);
    end
  endtask : move
  task automatic press();
    latch_in <= 1'b1;
    repeat (10) @(posedge hclk);
    latch_in <= 1'b0;
    repeat (10) @(posedge hclk);
  endtask : press
endmodule : epc_enc_model
`default_nettype wire

//--- sim/encoder_pulse_counter_tb.sv
// Self-checking bench for the encoder pulse counter.
// Assumes a zero-wait AHB-Lite slave and shortened ms and gate counts.
`timescale 1ns/1ps
`default_nettype none
module encoder_pulse_counter_tb;
  import epc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic cycle_tick = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic delta_valid;
  logic enc_a;
  logic enc_b;
  logic latch_in;
  logic [31:0] rv;
  int miscompares = 0;
  int cmp_count = 0;
  always #2.5 hclk = ~hclk;
  epc_counter #(.MS_CYCLES(20), .GATE_CYCLES(200)) u_epc_counter (.hclk(hclk),
    .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b),
    .latch_in(latch_in), .cycle_tick(cycle_tick), .delta_valid(delta_valid));
  epc_enc_model u_epc_enc_model (.hclk(hclk), .enc_a(enc_a), .enc_b(enc_b),
    .latch_in(latch_in));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask : xfer
  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : cmpv
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    cmpv(rv, exp);
  endtask : chk
  task automatic wait_dv(output int n);
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end while (delta_valid !== 1'b1 && n < 300);
    if (delta_valid !== 1'b1)
    begin
      $display("ERROR %0t no delta update", $time);
      miscompares++;
    end
    @(posedge hclk);
  endtask : wait_dv
  task automatic tick();
    int n;
    cycle_tick <= 1'b1;
    @(posedge hclk);
    cycle_tick <= 1'b0;
    wait_dv(n);
  endtask : tick
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (30000) @(posedge hclk);
    miscompares++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    int n;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(EPC_CTRL_OFS, 32'h0000_0000);
    chk(EPC_PERIOD_OFS, 32'h0000_0001);
    chk(8'h1C, 32'h0000_0000);
    xfer(1'b1, EPC_CTRL_OFS, 32'h0000_0001);
    u_epc_enc_model.move(8, 1'b1, 100);
    chk(EPC_COUNT_OFS, 32'h0000_0008);
    u_epc_enc_model.move(3, 1'b0, 100);
    chk(EPC_COUNT_OFS, 32'h0000_0005);
    u_epc_enc_model.press();
    u_epc_enc_model.move(2, 1'b1, 100);
    chk(EPC_LATCH_OFS, 32'h0000_0005);
    chk(EPC_STATUS_OFS, 32'h0000_0001);
    xfer(1'b1, EPC_STATUS_OFS, 32'h0000_0001);
    chk(EPC_STATUS_OFS, 32'h0000_0000);
    tick();
    chk(EPC_DELTA_OFS, 32'h0000_0007);
    u_epc_enc_model.move(4, 1'b0, 100);
    tick();
    chk(EPC_DELTA_OFS, 32'hFFFF_FFFC);
    chk(EPC_COUNT_OFS, 32'h0000_0003);
    clk_en <= 1'b0;
    cycle_tick <= 1'b1;
    @(posedge hclk);
    cycle_tick <= 1'b0;
    repeat (10) @(posedge hclk);
    clk_en <= 1'b1;
    chk(EPC_DELTA_OFS, 32'hFFFF_FFFC);
    u_epc_enc_model.move(160, 1'b1, 5);
    chk(EPC_FREQ_OFS, 32'h0000_000A);
    chk(EPC_COUNT_OFS, 32'h0000_00A3);
    xfer(1'b1, EPC_CTRL_OFS, 32'h0000_0009);
    chk(EPC_COUNT_OFS, 32'h0000_0000);
    xfer(1'b1, EPC_PERIOD_OFS, 32'h0000_0002);
    xfer(1'b1, EPC_CTRL_OFS, 32'h0000_0003);
    wait_dv(n);
    wait_dv(n);
    cmpv(n, 32'h0000_0028);
    chk(EPC_DELTA_OFS, 32'h0000_0000);
    conclude();
  end
endmodule : encoder_pulse_counter_tb
`default_nettype wire
